// *** cqr_defs.svh ***
// Offsets, contents and widths of the extended query word table
`ifndef CQR_DEFS_SVH
`define CQR_DEFS_SVH
`define CQR_AW 8
`define CQR_DW 16
`define CQR_EXIT_CMD 8'hF0
`define CQR_MISS_VAL 16'h0000
`define CQR_OFS_SIG0 8'h40
`define CQR_VAL_SIG0 16'h0050
`define CQR_OFS_SIG1 8'h41
`define CQR_VAL_SIG1 16'h0052
`define CQR_OFS_SIG2 8'h42
`define CQR_VAL_SIG2 16'h0049
`define CQR_OFS_MAJOR 8'h43
`define CQR_VAL_MAJOR 16'h0031
`define CQR_OFS_MINOR 8'h44
`define CQR_VAL_MINOR 16'h0035
`define CQR_OFS_UNLOCK 8'h45
`define CQR_VAL_UNLOCK 16'h001C
`define CQR_OFS_ERS_SUSP 8'h46
`define CQR_VAL_ERS_SUSP 16'h0002
`define CQR_OFS_PROT_GRP 8'h47
`define CQR_VAL_PROT_GRP 16'h0001
`define CQR_OFS_TMP_UNPROT 8'h48
`define CQR_VAL_TMP_UNPROT 16'h0000
`define CQR_OFS_SCHEME 8'h49
`define CQR_VAL_SCHEME 16'h0008
`define CQR_OFS_BANKS 8'h4A
`define CQR_VAL_BANKS 16'h0000
`define CQR_OFS_BURST 8'h4B
`define CQR_VAL_BURST 16'h0001
`define CQR_OFS_PAGE_RD 8'h4C
`define CQR_VAL_PAGE_RD 16'h0000
`define CQR_OFS_ACC_MIN 8'h4D
`define CQR_VAL_ACC_MIN 16'h0000
`define CQR_OFS_ACC_MAX 8'h4E
`define CQR_VAL_ACC_MAX 16'h0000
`define CQR_OFS_WP_LAYOUT 8'h4F
`define CQR_VAL_WP_LAYOUT 16'h0000
`define CQR_OFS_PGM_SUSP 8'h50
`define CQR_VAL_PGM_SUSP 16'h0001
`define CQR_OFS_UNLK_SKIP 8'h51
`define CQR_VAL_UNLK_SKIP 16'h0000
`define CQR_OFS_OTP_EXP 8'h52
`define CQR_VAL_OTP_EXP 16'h000A
`define CQR_OFS_FEATURES 8'h53
`define CQR_VAL_FEATURES 16'h008D
`define CQR_OFS_PAGE_EXP 8'h54
`define CQR_VAL_PAGE_EXP 16'h0005
`define CQR_OFS_ERS_LAT 8'h55
`define CQR_VAL_ERS_LAT 16'h0006
`define CQR_OFS_PGM_LAT 8'h56
`define CQR_VAL_PGM_LAT 16'h0006
`define CQR_OFS_RSVD_LO 8'h57
`define CQR_OFS_RSVD_HI 8'h77
`define CQR_VAL_RSVD 16'hFFFF
`define CQR_OFS_PIN_RST 8'h78
`define CQR_VAL_PIN_RST 16'h0006
`define CQR_OFS_POR_RST 8'h79
`define CQR_VAL_POR_RST 16'h0009
`endif

// *** cqr_pkg.sv ***
// Types shared by the extended query table logic
package cqr_pkg;
    // Which address space the device currently answers from
    typedef enum logic [1:0] {
        CQR_SPACE_ARRAY = 2'b00,
        CQR_SPACE_ID = 2'b01,
        CQR_SPACE_QUERY = 2'b10
    } cqr_space_e;
    // One table word
    typedef logic [15:0] cqr_word_t;
endpackage

// *** cqr_ext_query_rom.sv ***
// Extended query word table with space entry, exit and read port
`timescale 1ns/1ps
`default_nettype none
`include "cqr_defs.svh"

// How it works
// - Offsets 40h-42h return the signature letters
// - Offsets 43h, 44h return ASCII version digits
// - Offset 45h returns unlock and process code
// - Offset 47h returns smallest protect group
// - Offset 49h returns advanced protection scheme
// - Offsets 4Dh, 4Eh report no acceleration supply
// - Offset 4Fh reports no write-protect boot
// - Offset 52h returns OTP size exponent
// - Offset 53h returns software feature bitmap
// - Offset 55h returns erase-suspend latency exponent
// - Offset 56h returns program-suspend latency exponent
// - Offsets 57h through 77h read all ones
// - Offset 78h returns pin reset exponent
// - Offset 79h returns power-on reset exponent
// - Both entry paths expose the same table
// - Offsets count words; command upper byte ignored
module cqr_ext_query_rom
    import cqr_pkg::*;
(
    input wire logic clk_sys_i, // System clock, 200 MHz
    input wire logic reset_i, // Asynchronous reset, active high
    input wire logic id_entry_i, // Pulse: identification entry decoded
    input wire logic query_entry_i, // Pulse: query entry decoded
    input wire logic rd_i, // Read request this cycle
    input wire logic wr_i, // Write (command) cycle this cycle
    input wire logic [7:0] addr_i, // Word offset from sector_base_address
    input wire logic [15:0] wdata_i, // Write data of a command cycle
    output logic [15:0] rdata_o, // Read data, valid with rvalid_o
    output logic rvalid_o, // One-cycle pulse per taken read
    output logic rhit_o, // Read was served from the table
    output logic space_active_o // Identification/query space entered
);

    // Current address space
    cqr_space_e space;
    // Next space value
    cqr_space_e next_space;
    // Table word looked up from the offset
    cqr_word_t table_word;
    // Offset falls inside the table range
    logic table_hit;
    // Host wrote the exit command
    logic exit_cmd;
    // Either entry path has opened the space
    logic in_space;

    // Only the low byte of a command cycle is decoded
    assign exit_cmd = wr_i && (wdata_i[7:0] == `CQR_EXIT_CMD);

    // Both entry states grant the same table
    assign in_space = (space == CQR_SPACE_ID) || (space == CQR_SPACE_QUERY);

    // Space sequencing; an entry in the exit cycle wins
    always_comb begin
        next_space = space;
        case (space)
            // Array reads: wait for an entry
            CQR_SPACE_ARRAY: begin
                if (query_entry_i) begin
                    next_space = CQR_SPACE_QUERY;
                end else if (id_entry_i) begin
                    next_space = CQR_SPACE_ID;
                end
            end
            // Identification space: stays until reset command or query entry
            CQR_SPACE_ID: begin
                if (query_entry_i) begin
                    next_space = CQR_SPACE_QUERY;
                end else if (exit_cmd && !id_entry_i) begin
                    next_space = CQR_SPACE_ARRAY;
                end
            end
            // Query space: stays until reset command or identification entry
            CQR_SPACE_QUERY: begin
                if (id_entry_i) begin
                    next_space = CQR_SPACE_ID;
                end else if (exit_cmd && !query_entry_i) begin
                    next_space = CQR_SPACE_ARRAY;
                end
            end
            // Illegal code falls back to array reads
            default: begin
                next_space = CQR_SPACE_ARRAY;
            end
        endcase
    end

    // Space register
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            space <= CQR_SPACE_ARRAY;
        end else begin
            space <= next_space;
        end
    end

    // Space flag for the surrounding read path
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            space_active_o <= 1'b0;
        end else begin
            space_active_o <= (next_space != CQR_SPACE_ARRAY);
        end
    end

    // Constant lookup; offsets are 16-bit word indices
    always_comb begin
        table_word = `CQR_MISS_VAL;
        table_hit = 1'b1;
        // Reserved block reads all ones
        if ((addr_i >= `CQR_OFS_RSVD_LO) && (addr_i <= `CQR_OFS_RSVD_HI)) begin
            table_word = `CQR_VAL_RSVD;
        end else begin
            case (addr_i)
                // Signature letters
                `CQR_OFS_SIG0: begin
                    table_word = `CQR_VAL_SIG0;
                end
                `CQR_OFS_SIG1: begin
                    table_word = `CQR_VAL_SIG1;
                end
                `CQR_OFS_SIG2: begin
                    table_word = `CQR_VAL_SIG2;
                end
                // Version digits in ASCII
                `CQR_OFS_MAJOR: begin
                    table_word = `CQR_VAL_MAJOR;
                end
                `CQR_OFS_MINOR: begin
                    table_word = `CQR_VAL_MINOR;
                end
                // Unlock sensitivity in [1:0], process in [5:2]
                `CQR_OFS_UNLOCK: begin
                    table_word = `CQR_VAL_UNLOCK;
                end
                // Erase suspend: read and write
                `CQR_OFS_ERS_SUSP: begin
                    table_word = `CQR_VAL_ERS_SUSP;
                end
                // Sectors in the smallest protect group
                `CQR_OFS_PROT_GRP: begin
                    table_word = `CQR_VAL_PROT_GRP;
                end
                // Temporary unprotect not offered
                `CQR_OFS_TMP_UNPROT: begin
                    table_word = `CQR_VAL_TMP_UNPROT;
                end
                // Advanced protection scheme code
                `CQR_OFS_SCHEME: begin
                    table_word = `CQR_VAL_SCHEME;
                end
                // No simultaneous banks
                `CQR_OFS_BANKS: begin
                    table_word = `CQR_VAL_BANKS;
                end
                // Burst reads offered
                `CQR_OFS_BURST: begin
                    table_word = `CQR_VAL_BURST;
                end
                // No page read mode
                `CQR_OFS_PAGE_RD: begin
                    table_word = `CQR_VAL_PAGE_RD;
                end
                // Acceleration supply absent, low and high
                `CQR_OFS_ACC_MIN: begin
                    table_word = `CQR_VAL_ACC_MIN;
                end
                `CQR_OFS_ACC_MAX: begin
                    table_word = `CQR_VAL_ACC_MAX;
                end
                // No write-protect boot layout
                `CQR_OFS_WP_LAYOUT: begin
                    table_word = `CQR_VAL_WP_LAYOUT;
                end
                // Program suspend offered
                `CQR_OFS_PGM_SUSP: begin
                    table_word = `CQR_VAL_PGM_SUSP;
                end
                // Unlock skip not offered
                `CQR_OFS_UNLK_SKIP: begin
                    table_word = `CQR_VAL_UNLK_SKIP;
                end
                // OTP area is two to this power bytes
                `CQR_OFS_OTP_EXP: begin
                    table_word = `CQR_VAL_OTP_EXP;
                end
                // Software feature bits
                `CQR_OFS_FEATURES: begin
                    table_word = `CQR_VAL_FEATURES;
                end
                // Page size exponent
                `CQR_OFS_PAGE_EXP: begin
                    table_word = `CQR_VAL_PAGE_EXP;
                end
                // Suspend latency exponents
                `CQR_OFS_ERS_LAT: begin
                    table_word = `CQR_VAL_ERS_LAT;
                end
                `CQR_OFS_PGM_LAT: begin
                    table_word = `CQR_VAL_PGM_LAT;
                end
                // Reset time exponents
                `CQR_OFS_PIN_RST: begin
                    table_word = `CQR_VAL_PIN_RST;
                end
                `CQR_OFS_POR_RST: begin
                    table_word = `CQR_VAL_POR_RST;
                end
                // Outside this table: not ours
                default: begin
                    table_word = `CQR_MISS_VAL;
                    table_hit = 1'b0;
                end
            endcase
        end
    end

    // Read data; writes never reach the table contents
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= `CQR_MISS_VAL;
        end else if (rd_i) begin
            if (in_space) begin
                rdata_o <= table_word;
            end else begin
                // Array reads are served elsewhere
                rdata_o <= `CQR_MISS_VAL;
            end
        end
    end

    // Read strobe, one cycle after the request
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
        end
    end

    // Tells the read mux whether this block owns the word
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rhit_o <= 1'b0;
        end else begin
            rhit_o <= rd_i && in_space && table_hit;
        end
    end

endmodule
`default_nettype wire

// *** cqr_ext_query_rom_assertions.sv ***
// Concurrent checks on the extended query table ports
`timescale 1ns/1ps
`default_nettype none
module cqr_ext_query_rom_assertions
    import cqr_pkg::*;
(
    input wire logic clk_sys_i, // Table clock
    input wire logic reset_i, // Async reset, active high
    input wire logic id_entry_i, // Identification entry pulse
    input wire logic query_entry_i, // Query entry pulse
    input wire logic rd_i, // Read request
    input wire logic wr_i, // Command write
    input wire logic [7:0] addr_i, // Word offset
    input wire logic [15:0] wdata_i, // Command data
    input wire logic [15:0] rdata_o, // Read data
    input wire logic rvalid_o, // Read answer strobe
    input wire logic rhit_o, // Answer came from table
    input wire logic space_active_o // Space entered
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // Read taken while the space is open
    wire logic in_rd = rd_i && space_active_o;
    wire logic any_entry = id_entry_i || query_entry_i;
    a_rvalid_follows_rd: assert property (rd_i |=> rvalid_o)
        else $error("read not answered next cycle");
    a_no_stray_rvalid: assert property (!rd_i |=> !rvalid_o && !rhit_o)
        else $error("answer without read");
    a_rdata_held: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data changed without read");
    a_sig_char0: assert property (in_rd && addr_i == 8'h40 |=> rdata_o == 16'h0050 && rhit_o)
        else $error("signature word wrong");
    a_minor_ver: assert property (in_rd && addr_i == 8'h44 |=> rdata_o == 16'h0035)
        else $error("minor version wrong");
    a_feature_map: assert property (in_rd && addr_i == 8'h53 |=> rdata_o == 16'h008D)
        else $error("feature bitmap wrong");
    a_reserved_ones: assert property (in_rd && addr_i inside {[8'h57:8'h77]} |=> rdata_o == 16'hFFFF)
        else $error("reserved word not all ones");
    a_por_exp: assert property (in_rd && addr_i == 8'h79 |=> rdata_o == 16'h0009 && rhit_o)
        else $error("power-on reset exponent wrong");
    a_array_miss: assert property (rd_i && !space_active_o |=> rdata_o == 16'h0000 && !rhit_o)
        else $error("table visible outside space");
    a_entry_opens: assert property (any_entry |=> space_active_o)
        else $error("entry did not open space");
    a_exit_closes: assert property (wr_i && wdata_i[7:0] == 8'hF0 && !any_entry |=> !space_active_o)
        else $error("exit command ignored");
    c_query_entry: cover property (query_entry_i ##1 in_rd);
    c_id_entry: cover property (id_entry_i ##1 in_rd);
    c_exit: cover property (space_active_o && wr_i ##1 !space_active_o);
endmodule
bind cqr_ext_query_rom cqr_ext_query_rom_assertions chk_u (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .id_entry_i(id_entry_i), .query_entry_i(query_entry_i), .rd_i(rd_i),
    .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .rhit_o(rhit_o), .space_active_o(space_active_o));
`default_nettype wire

// *** cqr_host_model.sv ***
// Host controller model that enters the space, reads words and issues commands
`timescale 1ns/1ps
`default_nettype none
module cqr_host_model (
    input wire logic clk_sys_i, // Bus clock
    input wire logic [15:0] rdata_i, // Read data
    input wire logic rvalid_i, // Answer strobe
    input wire logic rhit_i, // Answer from table
    output logic id_entry_o, // Identification entry pulse
    output logic query_entry_o, // Query entry pulse
    output logic rd_o, // Read request
    output logic wr_o, // Command write
    output logic [7:0] addr_o, // Word offset
    output logic [15:0] wdata_o // Command data
);
    // Bus idle at time zero
    initial begin
        {id_entry_o, query_entry_o, rd_o, wr_o, addr_o, wdata_o} = '0;
    end
    // One-cycle entry pulse, query or identification path
    task automatic enter(input logic query);
        rd_o = 1'b0;
        query_entry_o = query;
        id_entry_o = !query;
        @(negedge clk_sys_i);
        query_entry_o = 1'b0;
        id_entry_o = 1'b0;
    endtask
    // Word read; request stays up so reads can run back to back
    task automatic read_word(input logic [7:0] a, output logic [15:0] d, output logic [1:0] vh);
        rd_o = 1'b1;
        addr_o = a;
        @(negedge clk_sys_i);
        d = rdata_i;
        vh = {rvalid_i, rhit_i};
    endtask
    // Command cycle; F0 in the low byte leaves the space before array reads
    task automatic write_cmd(input logic [7:0] a, input logic [15:0] w);
        rd_o = 1'b0;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = w;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        wdata_o = ~w;
    endtask
endmodule
`default_nettype wire

// *** test_cqr_ext_query_rom.sv ***
// Self-checking bench for the extended query word table
`timescale 1ns/1ps
`default_nettype none
module test_cqr_ext_query_rom;
    logic clk_sys_i, reset_i, id_entry_i, query_entry_i, rd_i, wr_i, rvalid_o, rhit_o;
    logic space_active_o;
    logic [7:0] addr_i;
    logic [15:0] wdata_i, rdata_o, d;
    logic [1:0] vh;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    cqr_ext_query_rom dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .id_entry_i(id_entry_i),
        .query_entry_i(query_entry_i), .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rhit_o(rhit_o),
        .space_active_o(space_active_o));
    cqr_host_model host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .rhit_i(rhit_o), .id_entry_o(id_entry_i), .query_entry_o(query_entry_i), .rd_o(rd_i),
        .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected table word at a word offset
    function automatic logic [15:0] exp_word(input logic [7:0] a);
        if (a >= 8'h57 && a <= 8'h77) return 16'hFFFF;
        case (a)
            8'h40: return 16'h0050;
            8'h41: return 16'h0052;
            8'h42: return 16'h0049;
            8'h43: return 16'h0031;
            8'h44: return 16'h0035;
            8'h45: return 16'h001C;
            8'h46: return 16'h0002;
            8'h47: return 16'h0001;
            8'h49: return 16'h0008;
            8'h4B: return 16'h0001;
            8'h50: return 16'h0001;
            8'h52: return 16'h000A;
            8'h53: return 16'h008D;
            8'h54: return 16'h0005;
            8'h55: return 16'h0006;
            8'h56: return 16'h0006;
            8'h78: return 16'h0006;
            8'h79: return 16'h0009;
            default: return 16'h0000;
        endcase
    endfunction
    // Outputs cleared by reset; array space hides the table
    task automatic t_reset_state();
        chk(rdata_o, 16'h0000);
        chk({13'h0, rvalid_o, rhit_o, space_active_o}, 16'h0000);
        host_u.read_word(8'h40, d, vh);
        chk(d, 16'h0000);
        chk({14'h0, vh}, 16'h0002);
        host_u.write_cmd(8'h00, 16'h00F0);
    endtask
    // Back-to-back sweep over the table and its edges through one entry path
    task automatic t_sweep(input logic query);
        host_u.enter(query);
        chk({15'h0, space_active_o}, 16'h0001);
        for (int a = 'h3F; a <= 'h7A; a++) begin
            host_u.read_word(8'(a), d, vh);
            chk(d, exp_word(8'(a)));
            chk({14'h0, vh}, {14'h0, 1'b1, a >= 'h40 && a <= 'h79});
        end
    endtask
    // Writes leave words alone; exit ignores the upper byte
    task automatic t_write_exit();
        host_u.write_cmd(8'h40, 16'hFF55);
        host_u.read_word(8'h40, d, vh);
        chk(d, 16'h0050);
        host_u.write_cmd(8'h40, 16'h12F0);
        chk({15'h0, space_active_o}, 16'h0000);
        host_u.read_word(8'h40, d, vh);
        chk(d, 16'h0000);
        host_u.write_cmd(8'h00, 16'h0000);
    endtask
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Clock at 200 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        reset_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        reset_i = 1'b0;
        t_reset_state();
        t_sweep(1'b1);
        t_write_exit();
        t_sweep(1'b0);
        t_write_exit();
        print_verdict();
    end
endmodule
`default_nettype wire
